// file: verilog/trig_dec_pkg.sv
`default_nettype none

package trig_dec_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [7:0] ADDR_CFG  = 8'h18;
    localparam logic [7:0] ADDR_MODE = 8'h40;
    localparam logic [7:0] ADDR_STAT = 8'h41;
    localparam logic [7:0] ADDR_CLR  = 8'h42;
    localparam logic [7:0] ADDR_EN   = 8'h43;

    // Configuration register fields and value after reset.
    localparam int         CFG_BURST_BIT   = 7;
    localparam int         CFG_INSIDE_BIT  = 6;
    localparam int         CFG_OUTSIDE_BIT = 5;
    localparam int         CFG_ORIENT_BIT  = 4;
    localparam int         CFG_ROLE_BIT    = 2;
    localparam logic [7:0] CFG_RESET       = 8'h01;

    // Mode register fields: decimation code, low power, buffer mode.
    localparam int         MODE_DEC_LSB  = 0;
    localparam int         MODE_LP_BIT   = 4;
    localparam int         MODE_BUF_LSB  = 5;
    localparam logic [6:0] MODE_RESET    = 7'h00;
    localparam logic [1:0] BUF_MODE_REGS = 2'h0;

    // Status and interrupt bits.
    localparam int         STAT_READY_BIT = 0;
    localparam int         STAT_DROP_BIT  = 1;
    localparam logic [1:0] STAT_RESET     = 2'h0;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam real SAMPLE_TIME_MS = 0.3125;
    localparam real CLK_PERIOD_NS  = 100.0;
    localparam int  CONV_CYCLES    = int'(SAMPLE_TIME_MS * 1.0e6 / CLK_PERIOD_NS);

    // Decimation limits.
    localparam logic [3:0]  DEC_SAT_CODE = 4'hC;
    localparam logic [12:0] SAMPLES_MAX  = 13'h1000;
    localparam logic [12:0] SAMPLES_ONE  = 13'h0001;

    // Sequencer states, Gray coded along idle, convert, store.
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CONV  = 2'b01,
        ST_STORE = 2'b11
    } seq_state_t;

    // Samples per output from the decimation code; low power forces one.
    function automatic logic [12:0] samples_of(input logic [3:0] code, input logic lp);
        logic [12:0] n;
        n = SAMPLES_MAX;
        if (lp) begin
            n = SAMPLES_ONE;
        end else if (code < DEC_SAT_CODE) begin
            n = SAMPLES_ONE << code;
        end
        return n;
    endfunction

endpackage

`default_nettype wire

// file: verilog/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Two-stage synchroniser for an asynchronous pin
// ==========================================================
module pin_sync (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Pin and synchronised level
    input  wire logic pin_in,
    output logic      pin_sync_out
);

    typedef struct packed {
        logic meta;
        logic stable;
    } sync_t;

    sync_t q;
    sync_t q_nxt;

    // Only the second stage reads the first.
    always_comb begin
        q_nxt.meta   = pin_in;
        q_nxt.stable = q.meta;
    end

    // Both stages clear on reset.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= q_nxt;
        end
    end

    assign pin_sync_out = q.stable;

endmodule

`default_nettype wire

// file: verilog/conv_timer.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Single conversion timer
// ==========================================================
module conv_timer
    import trig_dec_pkg::*;
#(
    parameter int CYCLES = CONV_CYCLES
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Start pulse and completion pulse
    input  wire logic start,
    output logic      done
);

    typedef struct packed {
        logic        busy;
        logic [11:0] cnt;
        logic        done;
    } timer_t;

    timer_t q;
    timer_t q_nxt;

    // Counts one sample time, then pulses done for one cycle.
    always_comb begin
        q_nxt      = q;
        q_nxt.done = 1'b0;
        if (start && !q.busy) begin
            q_nxt.busy = 1'b1;
            q_nxt.cnt  = '0;
        end else if (q.busy) begin
            if (q.cnt == 12'(CYCLES - 1)) begin
                q_nxt.busy = 1'b0;
                q_nxt.done = 1'b1;
            end else begin
                q_nxt.cnt = q.cnt + 12'h001;
            end
        end
    end

    // Timer registers.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= q_nxt;
        end
    end

    assign done = q.done;

endmodule

`default_nettype wire

// file: verilog/accel_trigger_decimation_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module accel_trigger_decimation_ctrl
    import trig_dec_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Trigger pin, asynchronous
    input  wire logic       trig_pin,
    // Change detector and orientation events, same clock
    input  wire logic       cd_inside_evt,
    input  wire logic       cd_outside_evt,
    input  wire logic       orient_evt,
    // Conversion control and results
    output logic            adc_start,
    output logic            result_store,
    output logic            store_to_buffer,
    output logic            wake_request,
    output logic            irq
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        seq_state_t  st;
        logic [12:0] cnt;
        logic [7:0]  cfg;
        logic [6:0]  mode;
        logic [1:0]  stat;
        logic [1:0]  irq_en;
        logic [7:0]  rdata;
        logic        irq;
        logic        adc_start;
        logic        store;
        logic        to_buf;
        logic        wake;
        logic        trig_prev;
    } state_t;

    state_t q;
    state_t q_nxt;

    logic        trig_sync;
    logic        conv_done;
    logic        trig_edge;
    logic        burst_eff;
    logic [3:0]  dec_code;
    logic        lp_mode;
    logic [1:0]  buf_mode;
    logic [12:0] samples;

    // ==========================================================
    // Submodules
    // ==========================================================
    pin_sync u_trig_sync (
        .core_clk     (core_clk),
        .rst          (rst),
        .pin_in       (trig_pin),
        .pin_sync_out (trig_sync)
    );

    conv_timer #(
        .CYCLES (CONV_CYCLES)
    ) u_conv_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .start    (q.adc_start),
        .done     (conv_done)
    );

    // ==========================================================
    // Decode of configuration
    // ==========================================================
    // Field extraction and effective modes.
    assign dec_code  = q.mode[MODE_DEC_LSB +: 4];
    assign lp_mode   = q.mode[MODE_LP_BIT];
    assign buf_mode  = q.mode[MODE_BUF_LSB +: 2];
    assign samples   = samples_of(dec_code, lp_mode);
    assign burst_eff = q.cfg[CFG_BURST_BIT] && q.cfg[CFG_ROLE_BIT];
    assign trig_edge = trig_sync && !q.trig_prev && q.cfg[CFG_ROLE_BIT];

    // ==========================================================
    // Next state
    // ==========================================================
    // Sequencer, register port, status and wake logic.
    always_comb begin
        logic [1:0] stat_set;
        logic [1:0] stat_clr;
        stat_set = '0;
        stat_clr = '0;
        q_nxt           = q;
        q_nxt.trig_prev = trig_sync;
        q_nxt.adc_start = 1'b0;
        q_nxt.store     = 1'b0;
        q_nxt.rdata     = '0;

        unique case (q.st)
            ST_IDLE: begin
                if (trig_edge) begin
                    q_nxt.adc_start = 1'b1;
                    q_nxt.st        = ST_CONV;
                end
            end
            ST_CONV: begin
                if (trig_edge && burst_eff) begin
                    stat_set[STAT_DROP_BIT] = 1'b1;
                end
                if (conv_done) begin
                    q_nxt.cnt = q.cnt + 13'h0001;
                    if (q.cnt + 13'h0001 >= samples) begin
                        q_nxt.st = ST_STORE;
                    end else if (burst_eff) begin
                        q_nxt.adc_start = 1'b1;
                    end else begin
                        q_nxt.st = ST_IDLE;
                    end
                end
            end
            ST_STORE: begin
                q_nxt.store  = 1'b1;
                q_nxt.to_buf = (buf_mode != BUF_MODE_REGS);
                q_nxt.cnt    = '0;
                q_nxt.st     = ST_IDLE;
                if (buf_mode == BUF_MODE_REGS) begin
                    stat_set[STAT_READY_BIT] = 1'b1;
                end
            end
            default: begin
                q_nxt.st = ST_IDLE;
            end
        endcase

        // Register writes.
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_CFG:  q_nxt.cfg    = reg_wdata;
                ADDR_MODE: q_nxt.mode   = reg_wdata[6:0];
                ADDR_CLR:  stat_clr     = reg_wdata[1:0];
                ADDR_EN:   q_nxt.irq_en = reg_wdata[1:0];
                default:   ;
            endcase
        end

        // Register reads, data one cycle later; unmapped reads give zero.
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_CFG:  q_nxt.rdata = q.cfg;
                ADDR_MODE: q_nxt.rdata = {1'b0, q.mode};
                ADDR_STAT: q_nxt.rdata = {6'h00, q.stat};
                ADDR_EN:   q_nxt.rdata = {6'h00, q.irq_en};
                default:   q_nxt.rdata = '0;
            endcase
        end

        // Sticky status: a set in the clearing cycle wins.
        q_nxt.stat = (q.stat & ~stat_clr) | stat_set;
        q_nxt.irq  = |(q_nxt.stat & q_nxt.irq_en);

        // Enabled detector events block sleep entry and force exit.
        q_nxt.wake = (cd_inside_evt && q.cfg[CFG_INSIDE_BIT])
                  || (cd_outside_evt && q.cfg[CFG_OUTSIDE_BIT])
                  || (orient_evt && q.cfg[CFG_ORIENT_BIT]);
    end

    // ==========================================================
    // Registers
    // ==========================================================
    // All state, with configuration bit 0 high after reset.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q <= '{st: ST_IDLE, cfg: CFG_RESET, mode: MODE_RESET,
                   stat: STAT_RESET, default: '0};
        end else begin
            q <= q_nxt;
        end
    end

    // Outputs straight from flip-flops.
    assign reg_rdata       = q.rdata;
    assign adc_start       = q.adc_start;
    assign result_store    = q.store;
    assign store_to_buffer = q.to_buf;
    assign wake_request    = q.wake;
    assign irq             = q.irq;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // Helper: cycles since the last conversion start.
    logic [12:0] conv_age_r;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            conv_age_r <= '0;
        end else if (q.adc_start) begin
            conv_age_r <= 13'h0001;
        end else begin
            conv_age_r <= conv_age_r + 13'h0001;
        end
    end

    sequence s_single_edge;
        q.st == ST_IDLE && trig_edge && !burst_eff;
    endsequence

    sequence s_start_then_conv;
        q.adc_start && q.st == ST_CONV;
    endsequence

    a_dec_saturate: assert property (
        !lp_mode |-> samples == ((dec_code >= DEC_SAT_CODE) ? SAMPLES_MAX
                                 : (SAMPLES_ONE << dec_code)))
        else $error("decimation code decoded to wrong sample count");

    a_conv_length: assert property (
        conv_done |-> conv_age_r == 13'(CONV_CYCLES + 1))
        else $error("conversion did not last one sample time");

    a_cfg_readback: assert property (
        reg_wr && reg_addr == ADDR_CFG ##1 reg_rd && reg_addr == ADDR_CFG
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("configuration register readback mismatch");

    a_single_start: assert property (
        s_single_edge |=> s_start_then_conv)
        else $error("trigger edge did not start one conversion");

    a_burst_chain: assert property (
        q.st == ST_CONV && conv_done && burst_eff && q.cnt + 13'h0001 < samples
        |=> q.adc_start)
        else $error("burst did not chain the next conversion");

    a_role_gate: assert property (
        q.st == ST_IDLE && !q.cfg[CFG_ROLE_BIT] |=> !q.adc_start)
        else $error("conversion started while pin is not a trigger");

    a_ready_cause: assert property (
        $rose(q.stat[STAT_READY_BIT]) |-> $past(q.st) == ST_STORE
        && $past(buf_mode) == BUF_MODE_REGS)
        else $error("ready flag set without a register result");

    a_lp_single: assert property (
        lp_mode |-> samples == SAMPLES_ONE)
        else $error("low power did not fix decimation at one");

    a_inside_wake: assert property (
        cd_inside_evt && q.cfg[CFG_INSIDE_BIT] |=> wake_request)
        else $error("enabled inside-window event did not wake");

    a_inside_ignored: assert property (
        !cd_outside_evt && !orient_evt && !q.cfg[CFG_INSIDE_BIT] |=> !wake_request)
        else $error("disabled inside-window event caused wake");

    a_burst_drop: assert property (
        q.st == ST_CONV && trig_edge && burst_eff |=> q.stat[STAT_DROP_BIT] ##0
        q.st != ST_IDLE || q.store)
        else $error("trigger during burst not ignored");

    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read answer");

    a_store_pulse: assert property (
        result_store |=> !result_store)
        else $error("result store lasted longer than one cycle");

    a_single_return: assert property (
        q.st == ST_CONV && conv_done && !burst_eff && q.cnt + 13'h0001 < samples
        |=> q.st == ST_IDLE && !q.adc_start)
        else $error("single mode did not wait for the next edge");

    a_ready_set_wins: assert property (
        q.st == ST_STORE && buf_mode == BUF_MODE_REGS |=> q.stat[STAT_READY_BIT])
        else $error("ready flag lost when result stored to registers");

    a_buffer_no_ready: assert property (
        q.st == ST_STORE && buf_mode != BUF_MODE_REGS && !q.stat[STAT_READY_BIT]
        |=> !q.stat[STAT_READY_BIT])
        else $error("ready flag raised for a buffered result");

endmodule

`default_nettype wire

// file: bench/host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Host side: drives the trigger pin and watches conversions
// ==========================================================
module host_model (
    // Clock
    input  wire logic core_clk,
    // Conversion outputs of the block
    input  wire logic adc_start,
    input  wire logic result_store,
    // Trigger pin
    output logic      trig_pin
);
    int n_start = 0;
    int n_store = 0;
    int gap     = 0;
    int cyc     = 0;
    int last    = 0;

    initial trig_pin = 1'b0;

    // Counts starts and stores and keeps the spacing of the last two starts.
    always @(posedge core_clk) begin
        cyc++;
        if (adc_start) begin
            gap = cyc - last;
            last = cyc;
            n_start++;
        end
        if (result_store) n_store++;
    end

    // One rising edge, placed off the clock edge since the pin is asynchronous.
    task automatic trig_edge();
        @(posedge core_clk);
        #30 trig_pin = 1'b1;
        repeat (4) @(posedge core_clk);
        #30 trig_pin = 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
endmodule

`default_nettype wire

// file: bench/accel_trigger_decimation_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end

module accel_trigger_decimation_ctrl_tb;
    import trig_dec_pkg::*;

    logic       core_clk;
    logic       rst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic [7:0] rv;
    logic [2:0] ev;
    logic       sb;
    logic       trig_pin;
    logic       cd_inside_evt;
    logic       cd_outside_evt;
    logic       orient_evt;
    logic       adc_start;
    logic       result_store;
    logic       store_to_buffer;
    logic       wake_request;
    logic       irq;
    int         mismatches = 0;
    int         n_compared = 0;
    int         seed       = 32'he652;
    bit         q[$];
    logic [7:0] wcfg[5]    = '{8'h01, 8'h41, 8'h21, 8'h11, 8'h71};

    accel_trigger_decimation_ctrl uut (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_pin(trig_pin),
        .cd_inside_evt(cd_inside_evt), .cd_outside_evt(cd_outside_evt),
        .orient_evt(orient_evt), .adc_start(adc_start), .result_store(result_store),
        .store_to_buffer(store_to_buffer), .wake_request(wake_request), .irq(irq));

    host_model host (
        .core_clk(core_clk), .adc_start(adc_start), .result_store(result_store),
        .trig_pin(trig_pin));

    // ==========================================================
    // Clock, result monitor and watchdog
    // ==========================================================
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Every stored result must land where the queued expectation says.
    always @(posedge core_clk) begin
        if (result_store) begin
            sb = q.size() ? q.pop_front() : 1'bx;
            `CHK(store_to_buffer, sb)
        end
    end

    // Cuts a hang short well past the expected run length.
    initial begin
        repeat (60000) @(posedge core_clk);
        mismatches++;
        summarize();
    end

    // ==========================================================
    // Register port tasks and the decimation model
    // ==========================================================
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask

    // Samples per output: a power of two, saturating, one in low power.
    function automatic int exp_n(input int c, input int lp);
        return lp ? 1 : (c > 11 ? 4096 : 1 << c);
    endfunction

    // Configures, fires trigger edges, then checks starts, stores and status.
    task automatic meas(input logic [7:0] c, input logic [7:0] m, input int edges,
                        input int spacing, input int est, input int eso,
                        input logic [1:0] estat);
        int s0;
        int t0;
        int k;
        wr(ADDR_CFG, c);
        wr(ADDR_MODE, m);
        wr(ADDR_CLR, 8'h03);
        s0 = host.n_start;
        t0 = host.n_store;
        for (int e = 0; e < eso; e++) q.push_back(m[6:5] != 2'h0);
        for (int e = 0; e < edges; e++) begin
            host.trig_edge();
            repeat (spacing) @(posedge core_clk);
        end
        k = 0;
        while (host.n_store - t0 < eso && k < 20000) begin
            @(posedge core_clk);
            k++;
        end
        repeat (20) @(posedge core_clk);
        `CHK(host.n_start - s0, est)
        `CHK(host.n_store - t0, eso)
        rchk(ADDR_STAT, {6'h00, estat});
        `CHK(irq, |estat)
        $display("test done cfg=%h mode=%h", c, m);
    endtask

    task automatic summarize();
        $display("compared=%0d mismatches=%0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence; setup is only changed while the block is idle
    // ==========================================================
    initial begin
        rst            = 1'b1;
        reg_addr       = 8'h00;
        reg_wdata      = 8'h00;
        reg_wr         = 1'b0;
        reg_rd         = 1'b0;
        cd_inside_evt  = 1'b0;
        cd_outside_evt = 1'b0;
        orient_evt     = 1'b0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rchk(ADDR_CFG, 8'h01);
        rchk(ADDR_MODE, 8'h00);
        rchk(ADDR_STAT, 8'h00);
        rchk(ADDR_EN, 8'h00);
        rchk(8'h77, 8'h00);
        rv = 8'($random(seed));
        // Write then read back with no idle cycle between the two strobes.
        @(posedge core_clk);
        reg_addr  <= ADDR_CFG;
        reg_wdata <= rv;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, rv)
        $display("test done registers");
        // Random events against five wake enable patterns: none, each enable alone, all three.
        for (int j = 0; j < 5; j++) begin
            wr(ADDR_CFG, wcfg[j]);
            for (int i = 0; i < 40; i++) begin
                @(posedge core_clk);
                ev = {cd_inside_evt, cd_outside_evt, orient_evt};
                rv = 8'($random(seed));
                {cd_inside_evt, cd_outside_evt, orient_evt} <= rv[2:0];
                #1;
                if (i > 0) `CHK(wake_request, |(ev & wcfg[j][6:4]))
            end
        end
        @(posedge core_clk);
        {cd_inside_evt, cd_outside_evt, orient_evt} <= 3'h0;
        $display("test done wake");
        wr(ADDR_EN, 8'h03);
        meas(8'h05, 8'h01, 2, 3300, 2, 1, 2'h1);
        meas(8'h85, 8'h01, 2, 100, exp_n(1, 0), 1, 2'h3);
        `CHK(host.gap inside {[3125:3135]}, 1'b1)
        wr(ADDR_EN, 8'h00);
        rchk(ADDR_EN, 8'h00);
        `CHK(irq, 1'b0)
        wr(ADDR_EN, 8'h03);
        meas(8'h81, 8'h01, 1, 50, 0, 0, 2'h0);
        meas(8'h85, 8'h13, 1, 0, exp_n(3, 1), 1, 2'h1);
        meas(8'h05, 8'h20, 1, 0, 1, 1, 2'h0);
        summarize();
    end
endmodule

`default_nettype wire
